// File: design/ismhs_core.sv
// Two-wire interface: bit-banged master and hardware slave.
// Assumes single-cycle register strobes from the core on i_clk_sys and
// a free-running link sampling clock; pins are open-drain outside.
`timescale 1ns/10ps
module ismhs_core (
  input wire logic i_clk_sys, // Core clock, 10 MHz
  input wire logic i_rst_n, // Async reset, active low
  input wire logic i_clk_link, // Pin sampling clock
  input wire ismhs_pkg::ismhs_sfr_req_t i_sfr, // Register request
  input wire logic i_spi_sel, // Shared port select
  input wire logic i_irq_en, // Interface interrupt enable
  input wire logic i_gie, // Global interrupt enable
  input wire logic i_sda_in, // Data pin level
  input wire logic i_scl_in, // Clock pin level
  output ismhs_pkg::ismhs_pin_drv_t o_pins, // Pin drive and enables
  output logic [7:0] o_sfr_rdata, // Register read data
  output logic o_irq, // Core interrupt request
  output logic [15:0] o_irq_vector // Interrupt entry address
);
  import ismhs_pkg::*;

  // -------------------------------------------------------------
  // Link domain: synchronise and filter both lines
  // -------------------------------------------------------------
  logic [1:0] lk_raw;
  logic [1:0] lk_s1_reg;
  logic [1:0] lk_s2_reg;
  logic [1:0] lk_filt_reg;
  assign lk_raw = {i_scl_in, i_sda_in};

  // Two flops before the filter sees the pins
  always_ff @(posedge i_clk_link or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lk_s1_reg <= 2'h3;
      lk_s2_reg <= 2'h3;
    end else begin
      lk_s1_reg <= lk_raw;
      lk_s2_reg <= lk_s1_reg;
    end
  end

  // A new level is taken only after it stays for more than the spike time
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_filt
      logic [1:0] cnt_reg;
      always_ff @(posedge i_clk_link or negedge i_rst_n) begin
        if (!i_rst_n) begin
          cnt_reg <= 2'h0;
          lk_filt_reg[gi] <= 1'b1;
        end else if (lk_s2_reg[gi] == lk_filt_reg[gi]) begin
          cnt_reg <= 2'h0;
        end else if (cnt_reg >= 2'(FILT_CYC)) begin
          cnt_reg <= 2'h0;
          lk_filt_reg[gi] <= lk_s2_reg[gi];
        end else begin
          cnt_reg <= cnt_reg + 2'h1;
        end
      end
    end
  endgenerate

  // -------------------------------------------------------------
  // Core domain: bring filtered levels across
  // -------------------------------------------------------------
  logic [1:0] cx1_reg;
  logic [1:0] cx2_reg;
  logic [1:0] prev_reg;
  logic sda;
  logic scl;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  // Levels only cross, so two flops suffice
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cx1_reg <= 2'h3;
      cx2_reg <= 2'h3;
      prev_reg <= 2'h3;
    end else begin
      cx1_reg <= lk_filt_reg;
      cx2_reg <= cx1_reg;
      prev_reg <= cx2_reg;
    end
  end

  // Bus events from the settled lines
  assign sda = cx2_reg[0];
  assign scl = cx2_reg[1];
  assign scl_rise = scl & ~prev_reg[1];
  assign scl_fall = ~scl & prev_reg[1];
  assign start_det = scl & prev_reg[1] & prev_reg[0] & ~sda;
  assign stop_det = scl & prev_reg[1] & ~prev_reg[0] & sda;

  // -------------------------------------------------------------
  // Register access decode
  // -------------------------------------------------------------
  function automatic logic hit(input ismhs_sfr_req_t r, input logic [7:0] a);
    hit = (r.wr | r.rd) & (r.addr == a);
  endfunction

  logic dat_acc;
  logic ctl_wr;
  logic own_wr;
  assign dat_acc = hit(i_sfr, ADDR_BYTE_BUF);
  assign ctl_wr = i_sfr.wr & (i_sfr.addr == ADDR_CONTROL);
  assign own_wr = i_sfr.wr & (i_sfr.addr == ADDR_OWN_ADDR);

  logic dout_reg;
  logic dren_reg;
  logic cout_reg;
  logic din_reg;
  logic msel_reg;
  logic irst_reg;
  logic dir_reg;
  logic flag_reg;
  logic acc_done_reg;
  logic set_pulse_reg;
  logic [7:0] own_reg;
  logic [7:0] dat_reg;
  logic slave_on;
  assign slave_on = ~msel_reg & ~i_spi_sel & ~irst_reg;

  // Software-owned control bits; reset leaves slave mode
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dout_reg <= RST_CONTROL[BIT_MDATA_OUT];
      dren_reg <= RST_CONTROL[BIT_DRIVE_EN];
      cout_reg <= RST_CONTROL[BIT_MCLK_OUT];
      msel_reg <= RST_CONTROL[BIT_MASTER_SEL];
      irst_reg <= RST_CONTROL[BIT_IF_RESET];
    end else if (ctl_wr) begin
      dout_reg <= i_sfr.wdata[BIT_MDATA_OUT];
      dren_reg <= i_sfr.wdata[BIT_DRIVE_EN];
      cout_reg <= i_sfr.wdata[BIT_MCLK_OUT];
      msel_reg <= i_sfr.wdata[BIT_MASTER_SEL];
      irst_reg <= i_sfr.wdata[BIT_IF_RESET];
    end
  end

  // Own address, writable at any time
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      own_reg <= RST_OWN_ADDR;
    end else if (own_wr) begin
      own_reg <= i_sfr.wdata;
    end
  end

  // Data pin latched on each clock rise in master mode while not driving
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      din_reg <= 1'b0;
    end else if (msel_reg && !dren_reg && scl_rise) begin
      din_reg <= sda;
    end
  end

  // -------------------------------------------------------------
  // Slave controller
  // -------------------------------------------------------------
  ismhs_state_t state_reg;
  logic [7:0] shift_reg;
  logic [3:0] cnt_reg;
  logic sda_low_reg;
  logic nack_reg;
  logic hw_cap;
  logic addr_match;
  assign addr_match = shift_reg[7:1] == own_reg[6:0];
  assign hw_cap = scl_fall & (cnt_reg == 4'(BITS_PER_BYTE)) &
                  ((state_reg == ST_ADDR & addr_match) | state_reg == ST_RX);

  // Byte sequencing; interface reset wins over everything, stop over all but a halt
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= ST_IDLE;
      shift_reg <= 8'h00;
      cnt_reg <= 4'h0;
      sda_low_reg <= 1'b0;
      nack_reg <= 1'b0;
      dir_reg <= 1'b0;
      set_pulse_reg <= 1'b0;
    end else begin
      set_pulse_reg <= 1'b0;
      if (!slave_on) begin
        state_reg <= ST_IDLE;
        sda_low_reg <= 1'b0;
      end else if (dat_acc && acc_done_reg && !flag_reg) begin
        state_reg <= ST_HALT;
        sda_low_reg <= 1'b0;
      end else if (state_reg == ST_HALT) begin
        sda_low_reg <= 1'b0;
      end else if (stop_det) begin
        state_reg <= ST_IDLE;
        sda_low_reg <= 1'b0;
      end else if (start_det) begin
        state_reg <= ST_ADDR;
        cnt_reg <= 4'h0;
        sda_low_reg <= 1'b0;
      end else begin
        case (state_reg)
          ST_ADDR, ST_RX: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda};
              cnt_reg <= cnt_reg + 4'h1;
            end else if (scl_fall && cnt_reg == 4'(BITS_PER_BYTE)) begin
              if (state_reg == ST_ADDR && !addr_match) begin
                state_reg <= ST_IDLE;
              end else begin
                sda_low_reg <= 1'b1;
                state_reg <= (state_reg == ST_ADDR) ? ST_ADDR_ACK : ST_RX_ACK;
                if (state_reg == ST_ADDR) begin
                  dir_reg <= shift_reg[0];
                end
              end
            end
          end
          ST_ADDR_ACK, ST_RX_ACK: begin
            if (scl_fall) begin
              sda_low_reg <= 1'b0;
              set_pulse_reg <= 1'b1;
              state_reg <= ST_WAIT;
            end
          end
          ST_WAIT: begin
            // Clock is held until software has serviced the byte
            if (!flag_reg && !set_pulse_reg) begin
              cnt_reg <= 4'h0;
              if (dir_reg) begin
                shift_reg <= dat_reg;
                sda_low_reg <= ~dat_reg[7];
                state_reg <= ST_TX;
              end else begin
                state_reg <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_rise) begin
              cnt_reg <= cnt_reg + 4'h1;
            end else if (scl_fall) begin
              if (cnt_reg == 4'(BITS_PER_BYTE)) begin
                sda_low_reg <= 1'b0;
                state_reg <= ST_TX_ACK;
              end else begin
                shift_reg <= {shift_reg[6:0], 1'b0};
                sda_low_reg <= ~shift_reg[6];
              end
            end
          end
          ST_TX_ACK: begin
            if (scl_rise) begin
              nack_reg <= sda;
            end else if (scl_fall) begin
              set_pulse_reg <= 1'b1;
              state_reg <= nack_reg ? ST_IDLE : ST_WAIT;
            end
          end
          ST_IDLE: begin
            sda_low_reg <= 1'b0;
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Byte-done flag: a hardware set beats a clearing access; no source tag kept
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flag_reg <= RST_CONTROL[BIT_BYTE_DONE];
    end else if (set_pulse_reg) begin
      flag_reg <= 1'b1;
    end else if (dat_acc || !slave_on) begin
      flag_reg <= 1'b0;
    end
  end

  // Remembers that this interrupt has already been serviced
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_done_reg <= 1'b0;
    end else if (set_pulse_reg || irst_reg) begin
      acc_done_reg <= 1'b0;
    end else if (dat_acc && flag_reg) begin
      acc_done_reg <= 1'b1;
    end
  end

  // Data register: hardware capture has priority over a software write
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dat_reg <= RST_BYTE_BUF;
    end else if (slave_on && hw_cap) begin
      dat_reg <= shift_reg;
    end else if (i_sfr.wr && i_sfr.addr == ADDR_BYTE_BUF) begin
      dat_reg <= i_sfr.wdata;
    end
  end

  // -------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------
  logic [7:0] ctl_view;
  assign ctl_view = {dout_reg, dren_reg, cout_reg, din_reg, msel_reg, irst_reg, dir_reg, flag_reg};

  // Read data registered; unmapped addresses read zero
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sfr_rdata <= 8'h00;
    end else if (i_sfr.rd) begin
      case (i_sfr.addr)
        ADDR_BYTE_BUF: o_sfr_rdata <= dat_reg;
        ADDR_OWN_ADDR: o_sfr_rdata <= own_reg;
        ADDR_CONTROL: o_sfr_rdata <= ctl_view;
        default: o_sfr_rdata <= 8'h00;
      endcase
    end
  end

  // Interrupt needs both enables; the flag stays visible when masked
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
      o_irq_vector <= IRQ_VECTOR;
    end else begin
      o_irq <= flag_reg & i_irq_en & i_gie;
      o_irq_vector <= IRQ_VECTOR;
    end
  end

  // Pin drive; the SPI owns the pins while selected
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pins <= '0;
    end else if (i_spi_sel) begin
      o_pins <= '0;
    end else if (msel_reg) begin
      o_pins.sda_out <= dout_reg;
      o_pins.sda_oe <= dren_reg;
      o_pins.scl_out <= cout_reg;
      o_pins.scl_oe <= 1'b1;
    end else begin
      o_pins.sda_out <= 1'b0;
      o_pins.sda_oe <= sda_low_reg & ~irst_reg;
      o_pins.scl_out <= 1'b0;
      o_pins.scl_oe <= (state_reg == ST_WAIT) & ~irst_reg;
    end
  end

  // -------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  sequence s_master_drive;
    msel_reg && dren_reg && !i_spi_sel;
  endsequence
  sequence s_wait_held;
    (state_reg == ST_WAIT && slave_on && !msel_reg)[*2];
  endsequence
  sequence s_second_access;
    slave_on && dat_acc && acc_done_reg && !flag_reg;
  endsequence

  chk_master_data_drive: assert property (
    s_master_drive |=> o_pins.sda_oe && o_pins.sda_out == $past(dout_reg))
    else $error("data pin not driven from data-out bit");
  chk_master_data_input: assert property (msel_reg && !dren_reg |=> !o_pins.sda_oe)
    else $error("data pin driven while input");
  chk_master_clock_out: assert property (
    msel_reg && !i_spi_sel |=> o_pins.scl_oe && o_pins.scl_out == $past(cout_reg))
    else $error("clock pin not following clock-out bit");
  chk_ifreset_idle: assert property (irst_reg |=> state_reg == ST_IDLE && !o_pins.scl_oe)
    else $error("interface reset did not idle slave");
  chk_access_clears: assert property (dat_acc && !set_pulse_reg |=> !flag_reg)
    else $error("data access left flag set");
  chk_stretch_hold: assert property (s_wait_held |-> o_pins.scl_oe && !o_pins.scl_out)
    else $error("clock not held low while waiting");
  chk_double_halt: assert property (s_second_access |=> state_reg == ST_HALT)
    else $error("second access did not halt");
  chk_stop_idle: assert property (slave_on && stop_det && state_reg != ST_HALT |=> state_reg == ST_IDLE)
    else $error("stop did not return to idle");
  chk_irq_gate: assert property (o_irq |-> $past(flag_reg) && $past(i_irq_en) && $past(i_gie))
    else $error("interrupt raised without both enables");
  chk_spi_release: assert property (i_spi_sel |=> !o_pins.sda_oe && !o_pins.scl_oe)
    else $error("pins driven while shared port selected");
  chk_set_wins: assert property (set_pulse_reg && dat_acc |=> flag_reg)
    else $error("flag set lost to clearing access");

endmodule

// File: dv/ismhs_bus_master.sv
// Behavioural two-wire bus master that addresses the hardware slave.
// Assumes open-drain lines with pull-ups resolved in the bench.
`timescale 1ns/10ps
module ismhs_bus_master (
  output logic o_scl_drv, // 0 pulls clock low
  output logic o_sda_drv, // 0 pulls data low
  input wire logic i_scl, // Resolved clock line
  input wire logic i_sda // Resolved data line
);
  // -----------------------------------------------------------
  // Bus phases
  // -----------------------------------------------------------
  // Lines released while idle
  initial begin
    o_scl_drv = 1'b1;
    o_sda_drv = 1'b1;
  end

  // Release clock; bounded wait while the slave stretches it
  task automatic rise();
    o_scl_drv = 1'b1;
    for (int n = 0; n < 300 && i_scl !== 1'b1; n++) begin
      #100;
    end
    #1000;
  endtask

  task automatic start();
    o_sda_drv = 1'b1;
    rise();
    o_sda_drv = 1'b0;
    #1000;
    o_scl_drv = 1'b0;
  endtask

  task automatic stop();
    #500 o_sda_drv = 1'b0;
    rise();
    o_sda_drv = 1'b1;
    #1000;
  endtask

  // Data only moves while the clock is low
  task automatic bit_slot(input logic b, output logic got);
    #500 o_sda_drv = b;
    #500 rise();
    got = i_sda;
    o_scl_drv = 1'b0;
  endtask

  task automatic send(input logic [7:0] d, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(d[i], g);
    end
    bit_slot(1'b1, g);
    ack = ~g;
  endtask

  task automatic recv(input logic nack, output logic [7:0] d);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(1'b1, g);
      d[i] = g;
    end
    bit_slot(nack, g);
  endtask
endmodule

// File: dv/tb_top.sv
// Self-checking bench for the two-wire master and slave block.
// Assumes the behavioural bus master and pull-ups on both lines.
`timescale 1ns/10ps
module tb_top;
  import ismhs_pkg::*;
  typedef struct {logic [7:0] v; logic [7:0] m;} ismhs_note_t;
  logic i_clk_sys = 1'b0;
  logic i_clk_link = 1'b0;
  logic i_rst_n = 1'b0;
  ismhs_sfr_req_t sfr = '0;
  logic spi_sel = 1'b0;
  logic irq_en = 1'b0;
  logic gie = 1'b0;
  ismhs_pin_drv_t pins;
  logic [7:0] rdata;
  logic irq;
  logic [15:0] vec;
  logic m_scl;
  logic m_sda;
  wire scl;
  wire sda;
  int err_count = 0;
  int total_checks = 0;
  int seed = 61413;
  ismhs_note_t notes[$];
  ismhs_note_t cur;
  logic rd_seen = 1'b0;

  // -----------------------------------------------------------
  // Clocks, wires, instances
  // -----------------------------------------------------------
  always #50 i_clk_sys = ~i_clk_sys;
  // Link clock offset so the two never line up
  initial begin
    #17;
    forever #32 i_clk_link = ~i_clk_link;
  end
  assign sda = m_sda & (pins.sda_oe ? pins.sda_out : 1'b1);
  assign scl = m_scl & (pins.scl_oe ? pins.scl_out : 1'b1);

  ismhs_core uut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_clk_link(i_clk_link), .i_sfr(sfr),
    .i_spi_sel(spi_sel), .i_irq_en(irq_en), .i_gie(gie), .i_sda_in(sda), .i_scl_in(scl),
    .o_pins(pins), .o_sfr_rdata(rdata), .o_irq(irq), .o_irq_vector(vec));
  ismhs_bus_master mst (.o_scl_drv(m_scl), .o_sda_drv(m_sda), .i_scl(scl), .i_sda(sda));

  // -----------------------------------------------------------
  // Checking
  // -----------------------------------------------------------
  task automatic chk_bit(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask

  // Read data lands one cycle after the strobe; oldest note applies
  always @(posedge i_clk_sys) rd_seen <= sfr.rd;
  always @(negedge i_clk_sys) begin
    if (rd_seen) begin
      cur = notes.pop_front();
      if (cur.m != 8'h00) begin
        total_checks++;
        if ((rdata & cur.m) !== (cur.v & cur.m)) begin
          err_count++;
          $display("CHECK FAILED at %0t: read %h expected %h", $time, rdata, cur.v);
        end
      end
    end
  end

  task automatic report_and_stop();
    if (err_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // -----------------------------------------------------------
  // Register access, driven on the falling edge
  // -----------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk_sys);
    sfr = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge i_clk_sys);
    sfr.wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m, output logic [7:0] got);
    @(negedge i_clk_sys);
    sfr = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    notes.push_back(ismhs_note_t'{e, m});
    @(negedge i_clk_sys);
    sfr.rd = 1'b0;
    got = rdata;
  endtask

  // Polling is bounded so a dead slave cannot hang the run
  task automatic wait_flag(output logic [7:0] c);
    c = 8'h00;
    for (int n = 0; n < 500 && c[0] !== 1'b1; n++) begin
      rd(ADDR_CONTROL, 8'h00, 8'h00, c);
    end
    chk_bit(c[0], 1'b1, "byte done flag");
  endtask

  // Hang guard, well beyond the expected run
  initial begin
    #1000000;
    err_count++;
    report_and_stop();
  end

  // -----------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------
  initial begin
    logic [7:0] c;
    logic [7:0] d;
    logic [7:0] tx;
    logic ack;
    repeat (3) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    i_rst_n = 1'b1;
    rd(ADDR_BYTE_BUF, RST_BYTE_BUF, 8'hff, c);
    rd(ADDR_OWN_ADDR, RST_OWN_ADDR, 8'hff, c);
    rd(ADDR_CONTROL, RST_CONTROL, 8'hff, c);
    rd(8'h9c, 8'h00, 8'hff, c);
    chk_bit(vec === IRQ_VECTOR, 1'b1, "vector");
    // Master mode pin drive from random control values
    repeat (4) begin
      d = (8'($random(seed)) & 8'he0) | 8'h08;
      wr(ADDR_CONTROL, d);
      repeat (2) @(negedge i_clk_sys);
      chk_bit(pins.sda_oe, d[6], "data drive enable");
      chk_bit(pins.sda_out | ~d[6], d[7] | ~d[6], "data out");
      chk_bit(pins.scl_oe & (pins.scl_out ~^ d[5]), 1'b1, "clock out");
    end
    wr(ADDR_CONTROL, 8'he8);
    spi_sel = 1'b1;
    repeat (3) @(negedge i_clk_sys);
    chk_bit(pins.sda_oe | pins.scl_oe, 1'b0, "pins released");
    spi_sel = 1'b0;
    // Data pin latched only on a clock rise
    for (int v = 0; v < 2; v++) begin
      wr(ADDR_CONTROL, 8'h08);
      mst.o_sda_drv = v[0];
      repeat (10) @(negedge i_clk_sys);
      wr(ADDR_CONTROL, 8'h28);
      repeat (10) @(negedge i_clk_sys);
      mst.o_sda_drv = ~v[0];
      repeat (10) @(negedge i_clk_sys);
      rd(ADDR_CONTROL, {3'b000, v[0], 4'h0}, 8'h10, c);
    end
    // A clock spike shorter than the filter window must not latch the data pin
    mst.o_scl_drv = 1'b0;
    #40 mst.o_scl_drv = 1'b1;
    repeat (10) @(negedge i_clk_sys);
    rd(ADDR_CONTROL, 8'h10, 8'h10, c);
    mst.o_sda_drv = 1'b1;
    wr(ADDR_CONTROL, 8'h00);
    repeat (10) @(negedge i_clk_sys);
    // Slave receive: address, stretch, interrupt gating, data
    irq_en = 1'b1;
    gie = 1'b1;
    tx = 8'($random(seed));
    fork
      begin
        mst.start();
        mst.send({RST_OWN_ADDR[6:0], 1'b0}, ack);
        chk_bit(ack, 1'b1, "address ack");
        mst.send(tx, ack);
        chk_bit(ack, 1'b1, "data ack");
      end
      begin
        wait_flag(c);
        chk_bit(c[1], 1'b0, "direction rx");
        repeat (4) @(negedge i_clk_sys);
        chk_bit(pins.scl_oe & ~pins.scl_out, 1'b1, "clock held");
        chk_bit(irq, 1'b1, "irq raised");
        gie = 1'b0;
        repeat (3) @(negedge i_clk_sys);
        chk_bit(irq, 1'b0, "irq gated");
        rd(ADDR_BYTE_BUF, {RST_OWN_ADDR[6:0], 1'b0}, 8'hff, c);
        repeat (3) @(negedge i_clk_sys);
        chk_bit(pins.scl_oe, 1'b0, "clock released");
        rd(ADDR_CONTROL, 8'h00, 8'h01, c);
        wait_flag(c);
        rd(ADDR_BYTE_BUF, tx, 8'hff, c);
      end
    join
    mst.stop();
    // Slave transmit ending in a not-acknowledge
    tx = 8'($random(seed));
    fork
      begin
        mst.start();
        mst.send({RST_OWN_ADDR[6:0], 1'b1}, ack);
        mst.recv(1'b1, d);
        chk_bit(d === tx, 1'b1, "sent byte");
      end
      begin
        wait_flag(c);
        chk_bit(c[1], 1'b1, "direction tx");
        wr(ADDR_BYTE_BUF, tx);
        wait_flag(c);
        rd(ADDR_BYTE_BUF, 8'h00, 8'h00, c);
      end
    join
    mst.stop();
    // Foreign address is ignored and the slave stays idle
    mst.start();
    mst.send(8'h54, ack);
    chk_bit(ack, 1'b0, "foreign address");
    mst.stop();
    repeat (10) @(negedge i_clk_sys);
    chk_bit(pins.scl_oe | pins.sda_oe, 1'b0, "idle");
    // Double access halts; interface reset recovers
    fork
      begin
        mst.start();
        mst.send(8'haa, ack);
        mst.send(8'h5a, ack);
      end
      begin
        wait_flag(c);
        rd(ADDR_BYTE_BUF, 8'haa, 8'hff, c);
        rd(ADDR_BYTE_BUF, 8'h00, 8'h00, c);
      end
    join
    chk_bit(ack, 1'b0, "halted ack");
    rd(ADDR_CONTROL, 8'h00, 8'h01, c);
    wr(ADDR_CONTROL, 8'h04);
    wr(ADDR_CONTROL, 8'h00);
    mst.stop();
    fork
      begin
        mst.start();
        mst.send(8'haa, ack);
        chk_bit(ack, 1'b1, "ack after reset");
      end
      begin
        wait_flag(c);
        rd(ADDR_BYTE_BUF, 8'haa, 8'hff, c);
      end
    join
    mst.stop();
    report_and_stop();
  end
endmodule

// File: inc/ismhs_pkg.sv
// Constants and carrier types for the two-wire interface with
// software master and hardware slave.
// Assumes an 8-bit special-function-register bus from the core and
// open-drain data and clock pins resolved outside the design.
//
// Overview of operation
// - Master mode with drive enable puts the data-out bit on the data pin.
// - Drive enable bit 6 makes the data pin output when set, input when clear.
// - Master mode always drives the clock pin from the clock-out bit 5.
// - Without drive enable, data pin level is latched into bit 4 on clock rise.
// - Master select bit 3 picks software master; hardware slave after reset.
// - Interface reset bit 2 holds the slave in its idle state.
// - Direction bit 1 holds the received read/write bit.
// - Byte-done flag bit 0 sets per byte; any data register access clears it.
// - Slave waits for start, address match and read/write, then sets the flag.
// - Received 7-bit address is compared with own address, reset value 55H.
// - After the address byte the data register holds address and read/write.
// - After a valid address the slave holds clock low until the flag clears.
// - Second data register access in one interrupt halts until interface reset.
// - Flag rises for every byte with acknowledge and also on not-acknowledge.
// - Stop, or not-acknowledge at sequence end, returns the slave to idle.
// - No hardware bit tells address interrupts from data interrupts.
// - Interrupt use vectors the core to 003BH after each complete byte.
// - Core interrupt needs both interface and global enables; flag still pollable.
// - Data and clock inputs reject spikes shorter than 50 ns.
// - Interface works only while the shared port select bit is clear.
// - Control register resets to zero: slave mode, flags clear.
package ismhs_pkg;

  // -------------------------------------------------------------
  // Register addresses and reset values
  // -------------------------------------------------------------
  localparam logic [7:0] ADDR_BYTE_BUF = 8'h9a;
  localparam logic [7:0] ADDR_OWN_ADDR = 8'h9b;
  localparam logic [7:0] ADDR_CONTROL = 8'he8;
  localparam logic [7:0] RST_BYTE_BUF = 8'h00;
  localparam logic [7:0] RST_OWN_ADDR = 8'h55;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [15:0] IRQ_VECTOR = 16'h003b;

  // -------------------------------------------------------------
  // Control register bit positions
  // -------------------------------------------------------------
  localparam int BIT_MDATA_OUT = 7;
  localparam int BIT_DRIVE_EN = 6;
  localparam int BIT_MCLK_OUT = 5;
  localparam int BIT_MDATA_IN = 4;
  localparam int BIT_MASTER_SEL = 3;
  localparam int BIT_IF_RESET = 2;
  localparam int BIT_DIRECTION = 1;
  localparam int BIT_BYTE_DONE = 0;

  // -------------------------------------------------------------
  // Timing: spike rejection on the link clock
  // -------------------------------------------------------------
  localparam int SPIKE_NS = 50;
  localparam int LINK_PERIOD_NS = 64;
  localparam int FILT_CYC = (SPIKE_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam int BITS_PER_BYTE = 8;

  // -------------------------------------------------------------
  // Types
  // -------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WAIT, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK, ST_HALT
  } ismhs_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } ismhs_sfr_req_t;

  typedef struct packed {
    logic sda_out;
    logic sda_oe;
    logic scl_out;
    logic scl_oe;
  } ismhs_pin_drv_t;

endpackage
